/* chip_mode_controller.sv */
// Chip operating mode controller: reset, normal and system stop
//
// Notes on behaviour
// - Three modes: reset, normal, stop; normal may go to either other mode.
// - Reset mode halts serial, DMA and timers and clears their state.
// - Reset pin sampled on falling edge, rising edge in CPU mode 0.
// - Six successive low samples raise hold; reset mode follows one cycle later.
// - Five successive high samples leave reset and enter normal mode.
// - Reset mode floats upper address and data lines, outputs to defaults.
// - Reset mode drives wait high; other two-way lines become inputs.
// - Normal mode runs all units, allows interrupts and bus mastership.
// - Upper seven control bits read zero; software writes zeros.
// - Control bit zero: writing one enters stop, zero changes nothing.
// - Stop is entered in the same write that sets the stop bit.
// - Stopped device ignores register reads and writes until reset.
// - Stop withholds unit clocks; clock generator and reset logic run.
// - Stop disables the host bus interface entirely.
// - Stop is left only through reset mode, then normal follows.
// - Stop treats low address, busy, strobes as inputs; floats address, data.
// - Stop drives grant chain and wait high, releases interrupt, request by mode.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module chip_mode_controller
  import mode_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Device pins
  input wire logic reset_pin_n,
  input wire logic host_mode_select_lo,
  input wire logic host_mode_select_hi,
  // Register port
  input wire logic [mode_ctrl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mode_ctrl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [mode_ctrl_pkg::DATA_W-1:0] reg_rdata,
  // Unit control
  output logic serial_clock_en,
  output logic dma_clock_en,
  output logic timer_clock_en,
  output logic unit_reset,
  output logic irq_enable,
  output logic arbiter_enable,
  output logic bus_if_enable,
  // Pin state control
  output logic pin_override,
  output logic wait_out,
  output logic wait_oe,
  output logic bus_grant_chain_out,
  output logic bus_request_out,
  output logic int_oe,
  output logic addr_hi_oe_allow,
  output logic data_oe_allow,
  output logic ctrl_oe_allow,
  // Mode status
  output logic [1:0] chip_mode
);
  typedef struct packed {
    chip_mode_t mode;
    logic [1:0] msel_s1;
    logic [1:0] msel_s2;
    logic stop_req;
    logic [DATA_W-1:0] rdata;
    logic serial_clock_en;
    logic dma_clock_en;
    logic timer_clock_en;
    logic unit_reset;
    logic irq_enable;
    logic arbiter_enable;
    logic bus_if_enable;
    logic pin_override;
    logic wait_out;
    logic wait_oe;
    logic bus_grant_chain_out;
    logic bus_request_out;
    logic int_oe;
    logic addr_hi_oe_allow;
    logic data_oe_allow;
    logic ctrl_oe_allow;
    logic [1:0] chip_mode;
  } state_t;

  state_t q;
  state_t d;
  logic hold;
  logic mode0;
  logic mode0_d;
  logic write_lpc;
  logic [1:0] mode_code;

  qual_if qif ();

  reset_qualifier #(
    .LOW_COUNT(LOW_RUN),
    .HIGH_COUNT(HIGH_RUN)
  ) u_qual (
    .clock(clock),
    .reset(reset),
    .reset_pin_n(reset_pin_n),
    .qif(qif)
  );

  assign mode0 = (q.msel_s2 == CPU_MODE_0);
  assign qif.mode0 = mode0;
  assign hold = qif.hold;

  always_comb begin
    mode0_d = 1'b0;
    write_lpc = 1'b0;
    mode_code = MODE_CODE_RESET;
    d = q;
    // Mode select pins pass two flops
    d.msel_s1 = {host_mode_select_hi, host_mode_select_lo};
    d.msel_s2 = q.msel_s1;
    d.rdata = DATA_ZERO;
    write_lpc = reg_write && (reg_addr == LOW_POWER_CONTROL_ADDR);
    case (q.mode)
      MODE_RESET: begin
        d.stop_req = 1'b0;
        if (!hold) begin
          d.mode = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (hold) begin
          d.mode = MODE_RESET;
          d.stop_req = 1'b0;
        end else begin
          if (write_lpc && reg_wdata[STOP_BIT]) begin
            d.stop_req = 1'b1;
            d.mode = MODE_STOP;
          end
          if (reg_read) begin
            case (reg_addr)
              LOW_POWER_CONTROL_ADDR: begin
                d.rdata[STOP_BIT] = q.stop_req;
              end
              MODE_STATUS_ADDR: begin
                d.rdata[STATUS_MODE_LSB +: 2] = q.chip_mode;
                d.rdata[STATUS_CPU_LSB +: 2] = q.msel_s2;
              end
              default: begin
                d.rdata = DATA_ZERO;
              end
            endcase
          end
        end
      end
      MODE_STOP: begin
        // Register port is ignored here
        if (hold) begin
          d.mode = MODE_RESET;
          d.stop_req = 1'b0;
        end
      end
      default: begin
        d.mode = MODE_RESET;
      end
    endcase
    if (reset) begin
      d.mode = MODE_RESET;
      d.msel_s1 = CPU_MODE_0;
      d.msel_s2 = CPU_MODE_0;
      d.stop_req = 1'b0;
      d.rdata = DATA_ZERO;
    end
    mode0_d = (d.msel_s2 == CPU_MODE_0);
    case (d.mode)
      MODE_NORMAL: begin
        mode_code = MODE_CODE_NORMAL;
      end
      MODE_STOP: begin
        mode_code = MODE_CODE_STOP;
      end
      default: begin
        mode_code = MODE_CODE_RESET;
      end
    endcase
    d.chip_mode = mode_code;
    // Units run only in normal mode
    d.serial_clock_en = (d.mode == MODE_NORMAL);
    d.dma_clock_en = (d.mode == MODE_NORMAL);
    d.timer_clock_en = (d.mode == MODE_NORMAL);
    d.unit_reset = (d.mode == MODE_RESET);
    d.irq_enable = (d.mode == MODE_NORMAL);
    d.arbiter_enable = (d.mode == MODE_NORMAL);
    d.bus_if_enable = (d.mode == MODE_NORMAL);
    // Pin states outside normal mode
    d.pin_override = (d.mode != MODE_NORMAL);
    d.wait_out = 1'b1;
    d.wait_oe = (d.mode != MODE_NORMAL);
    d.bus_grant_chain_out = 1'b1;
    d.bus_request_out = !mode0_d;
    d.int_oe = 1'b0;
    d.addr_hi_oe_allow = (d.mode == MODE_NORMAL);
    d.data_oe_allow = (d.mode == MODE_NORMAL);
    d.ctrl_oe_allow = (d.mode == MODE_NORMAL);
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign reg_rdata = q.rdata;
  assign serial_clock_en = q.serial_clock_en;
  assign dma_clock_en = q.dma_clock_en;
  assign timer_clock_en = q.timer_clock_en;
  assign unit_reset = q.unit_reset;
  assign irq_enable = q.irq_enable;
  assign arbiter_enable = q.arbiter_enable;
  assign bus_if_enable = q.bus_if_enable;
  assign pin_override = q.pin_override;
  assign wait_out = q.wait_out;
  assign wait_oe = q.wait_oe;
  assign bus_grant_chain_out = q.bus_grant_chain_out;
  assign bus_request_out = q.bus_request_out;
  assign int_oe = q.int_oe;
  assign addr_hi_oe_allow = q.addr_hi_oe_allow;
  assign data_oe_allow = q.data_oe_allow;
  assign ctrl_oe_allow = q.ctrl_oe_allow;
  assign chip_mode = q.chip_mode;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence stop_write;
    q.mode == MODE_NORMAL && !hold && write_lpc && reg_wdata[STOP_BIT];
  endsequence
  sequence stopped_quiet;
    q.mode == MODE_STOP && !hold;
  endsequence
  sequence lpc_read;
    q.mode == MODE_NORMAL && !hold && reg_read && reg_addr == LOW_POWER_CONTROL_ADDR;
  endsequence
  sequence stopped_write;
    stopped_quiet ##0 reg_write;
  endsequence
  sequence status_read;
    q.mode == MODE_NORMAL && !hold && reg_read && reg_addr == MODE_STATUS_ADDR;
  endsequence
  sequence bus_idle;
    !reg_read;
  endsequence

  a_stop_entry: assert property (stop_write |=> q.mode == MODE_STOP && !q.bus_if_enable)
    else $error("stop write did not stop the chip");
  a_stop_bit_zero: assert property (
      q.mode == MODE_NORMAL && !hold && write_lpc && !reg_wdata[STOP_BIT]
      |=> q.mode == MODE_NORMAL)
    else $error("writing zero changed the mode");
  a_stop_sticky: assert property (stopped_quiet |=> q.mode == MODE_STOP && q.stop_req)
    else $error("stop left without reset");
  a_stop_no_read: assert property (stopped_quiet ##0 reg_read |=> reg_rdata == DATA_ZERO)
    else $error("read answered while stopped");
  a_reserved_zero: assert property (lpc_read |=> reg_rdata[DATA_W-1:1] == '0)
    else $error("reserved control bits read nonzero");
  a_stop_clocks: assert property (
      q.mode == MODE_STOP |-> !serial_clock_en && !dma_clock_en && !timer_clock_en)
    else $error("unit clock running while stopped");
  a_stop_pins: assert property (
      q.mode == MODE_STOP |-> bus_grant_chain_out && wait_out && wait_oe && !int_oe
      && bus_request_out == !mode0)
    else $error("stop pin state wrong");
  a_stop_float: assert property (
      q.mode == MODE_STOP |-> !addr_hi_oe_allow && !data_oe_allow && !ctrl_oe_allow
      && pin_override)
    else $error("stopped chip drives address or data");
  a_reset_pins: assert property (
      q.mode == MODE_RESET |-> unit_reset && wait_out && wait_oe && !data_oe_allow
      && !addr_hi_oe_allow && !ctrl_oe_allow)
    else $error("reset mode pin state wrong");
  a_enter_reset: assert property (
      hold && q.mode != MODE_RESET |=> q.mode == MODE_RESET && unit_reset)
    else $error("qualified reset did not enter reset mode");
  a_leave_reset: assert property (
      q.mode == MODE_RESET && !hold |=> q.mode == MODE_NORMAL ##0 irq_enable && arbiter_enable)
    else $error("reset mode not released");
  a_normal_runs: assert property (
      q.mode == MODE_NORMAL |-> serial_clock_en && dma_clock_en && timer_clock_en
      && bus_if_enable && !unit_reset)
    else $error("normal mode units not running");
  a_mode_legal: assert property (q.mode == MODE_STOP |=> q.mode != MODE_NORMAL)
    else $error("stop went straight to normal");
  a_status_code: assert property (q.mode == MODE_NORMAL |-> chip_mode == MODE_CODE_NORMAL)
    else $error("mode status code wrong");

  // Register port, mode status, unit and pin checks
  a_stop_no_write: assert property (
      stopped_write |=> q.mode == MODE_STOP && q.stop_req)
    else $error("write accepted while stopped");
  a_status_read: assert property (
      status_read |=> reg_rdata[STATUS_MODE_LSB +: 2] == MODE_CODE_NORMAL)
    else $error("status read gave wrong mode");
  a_read_idle: assert property (
      bus_idle |=> reg_rdata == DATA_ZERO)
    else $error("read data without a read");
  a_units_halted: assert property (
      q.mode != MODE_NORMAL |-> !serial_clock_en && !dma_clock_en && !timer_clock_en
      && !irq_enable && !arbiter_enable)
    else $error("units enabled outside normal mode");
  a_bus_if_off: assert property (
      q.mode == MODE_STOP |-> !bus_if_enable && !irq_enable && !arbiter_enable)
    else $error("host bus interface on while stopped");
  a_stop_code: assert property (
      q.mode == MODE_STOP |-> chip_mode == MODE_CODE_STOP)
    else $error("stop status code wrong");
  a_reset_code: assert property (
      q.mode == MODE_RESET |-> chip_mode == MODE_CODE_RESET)
    else $error("reset status code wrong");
  a_reset_exit: assert property (
      q.mode == MODE_RESET |=> q.mode != MODE_STOP)
    else $error("reset went straight to stop");
  a_normal_pins: assert property (
      q.mode == MODE_NORMAL |-> !pin_override && !wait_oe && addr_hi_oe_allow
      && data_oe_allow && ctrl_oe_allow)
    else $error("normal mode pin state wrong");
  a_reset_request: assert property (
      q.mode == MODE_RESET |-> bus_request_out == !mode0)
    else $error("reset mode bus request level wrong");
  a_reset_clears: assert property (
      q.mode == MODE_RESET |-> !q.stop_req)
    else $error("stop request kept in reset mode");
  a_normal_no_stop: assert property (
      q.mode == MODE_NORMAL |-> !q.stop_req)
    else $error("stop request set in normal mode");
  a_write_no_data: assert property (
      stop_write |=> reg_rdata == DATA_ZERO)
    else $error("stop write produced read data");
  a_reset_units: assert property (
      q.mode == MODE_RESET |-> unit_reset && pin_override)
    else $error("units not held in reset mode");
  a_normal_stays: assert property (
      q.mode == MODE_NORMAL && !hold |=> q.mode != MODE_RESET)
    else $error("reset mode without qualified reset");
  a_reset_holds: assert property (
      q.mode == MODE_RESET && hold |=> q.mode == MODE_RESET)
    else $error("reset mode left while pin held low");
  a_stop_bit_reads: assert property (
      lpc_read |=> reg_rdata[STOP_BIT] == 1'b0)
    else $error("stop bit read as set in normal mode");
  a_stop_no_reset: assert property (
      q.mode == MODE_STOP |-> !unit_reset)
    else $error("units reset while stopped");
endmodule : chip_mode_controller
`default_nettype wire

/* mode_ctrl_pkg.sv */
// Constants and types shared by the chip mode controller files
`default_nettype none
package mode_ctrl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] LOW_POWER_CONTROL_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] MODE_STATUS_ADDR = 8'h01;
  localparam int STOP_BIT = 0;
  localparam int STATUS_MODE_LSB = 0;
  localparam int STATUS_CPU_LSB = 2;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [1:0] MODE_CODE_RESET = 2'h0;
  localparam logic [1:0] MODE_CODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_CODE_STOP = 2'h2;
  localparam logic [1:0] CPU_MODE_0 = 2'h0;
  localparam int RUN_CNT_W = 3;
  localparam logic [RUN_CNT_W-1:0] LOW_RUN = 3'h6;
  localparam logic [RUN_CNT_W-1:0] HIGH_RUN = 3'h5;
  localparam logic [RUN_CNT_W-1:0] RUN_ONE = 3'h1;
  localparam logic [RUN_CNT_W-1:0] RUN_NONE = 3'h0;
  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_NORMAL,
    MODE_STOP
  } chip_mode_t;
endpackage : mode_ctrl_pkg
`default_nettype wire

/* qual_if.sv */
// Link between the mode sequencer and the reset pin qualifier
`timescale 1ns/1ps
`default_nettype none
interface qual_if;
  logic mode0;
  logic hold;
  modport ctrl (output mode0, input hold);
  modport qual (input mode0, output hold);
endinterface : qual_if
`default_nettype wire

/* reset_qualifier.sv */
// Reset pin sampler and run counters
`timescale 1ns/1ps
`default_nettype none
module reset_qualifier
  import mode_ctrl_pkg::*;
#(
  parameter logic [mode_ctrl_pkg::RUN_CNT_W-1:0] LOW_COUNT = mode_ctrl_pkg::LOW_RUN,
  parameter logic [mode_ctrl_pkg::RUN_CNT_W-1:0] HIGH_COUNT = mode_ctrl_pkg::HIGH_RUN
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Reset pin
  input wire logic reset_pin_n,
  // Sequencer side
  qual_if.qual qif
);
  typedef struct packed {
    logic pos_s1;
    logic pos_s2;
    logic prev;
    logic [RUN_CNT_W-1:0] low_cnt;
    logic [RUN_CNT_W-1:0] high_cnt;
    logic hold;
  } state_t;
  typedef struct packed {
    logic s1;
    logic s2;
  } neg_t;

  state_t q;
  state_t d;
  neg_t nq;
  neg_t nd;
  logic smp;

  // Falling edge sampling path
  always_comb begin
    nd.s1 = reset_pin_n;
    nd.s2 = nq.s1;
    if (reset) begin
      nd = '1;
    end
  end

  always_ff @(negedge clock) begin
    nq <= nd;
  end

  // Pick the active edge sample
  assign smp = qif.mode0 ? q.pos_s2 : nq.s2;

  always_comb begin
    d = q;
    d.pos_s1 = reset_pin_n;
    d.pos_s2 = q.pos_s1;
    d.prev = smp;
    if (smp != q.prev) begin
      d.low_cnt = smp ? RUN_NONE : RUN_ONE;
      d.high_cnt = smp ? RUN_ONE : RUN_NONE;
    end else if (smp) begin
      if (q.high_cnt != HIGH_COUNT) begin
        d.high_cnt = q.high_cnt + RUN_ONE;
      end
    end else begin
      if (q.low_cnt != LOW_COUNT) begin
        d.low_cnt = q.low_cnt + RUN_ONE;
      end
    end
    if (d.low_cnt == LOW_COUNT) begin
      d.hold = 1'b1;
    end else if (d.high_cnt == HIGH_COUNT) begin
      d.hold = 1'b0;
    end
    if (reset) begin
      d = '{pos_s1: 1'b1, pos_s2: 1'b1, prev: 1'b1,
            low_cnt: RUN_NONE, high_cnt: RUN_NONE, hold: 1'b1};
    end
  end

  always_ff @(posedge clock) begin
    q <= d;
  end

  assign qif.hold = q.hold;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence low_run;
    (!smp)[*6];
  endsequence
  sequence high_run;
    smp[*5];
  endsequence

  a_low_run_enters: assert property (low_run |=> q.hold)
    else $error("six low samples did not raise hold");
  a_high_run_leaves: assert property (high_run |=> !q.hold)
    else $error("five high samples did not drop hold");
  a_run_restart: assert property ((smp != q.prev) |=> q.low_cnt <= RUN_ONE && q.high_cnt <= RUN_ONE)
    else $error("run counters kept counting across a level change");
  a_short_low_kept: assert property (!q.hold && smp ##1 (!smp)[*3] ##1 smp |=> !q.hold)
    else $error("short low pulse raised hold");
endmodule : reset_qualifier
`default_nettype wire

/* reset_source_model.sv */
// Model of the host's reset source and mode select pins
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
  // Clock
  input wire logic clock,
  // Pins driven toward the device
  output logic reset_pin_n,
  output logic host_mode_select_lo,
  output logic host_mode_select_hi
);
  initial begin
    reset_pin_n = 1'b1;
    host_mode_select_lo = 1'b1;
    host_mode_select_hi = 1'b0;
  end

  // Low pulse of a chosen length, whole clock cycles
  task automatic pulse_low(input int cycles);
    @(posedge clock);
    reset_pin_n <= 1'b0;
    repeat (cycles) @(posedge clock);
    reset_pin_n <= 1'b1;
  endtask : pulse_low

  // Mode pins change only while the device is held in power-on reset
  task automatic set_cpu_mode(input logic [1:0] mode);
    @(posedge clock);
    host_mode_select_lo <= mode[0];
    host_mode_select_hi <= mode[1];
  endtask : set_cpu_mode
endmodule : reset_source_model
`default_nettype wire

/* chip_mode_controller_tb_top.sv */
// Self-checking testbench of the chip mode controller
`timescale 1ns/1ps
`default_nettype none
`define check_eq(name, exp, got) \
  begin checks_done++; if ((got) !== (exp)) begin errors++; \
  $display("FAIL %s expected %h seen %h", name, exp, got); end end
module chip_mode_controller_tb_top;
  import mode_ctrl_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  wire logic reset_pin_n;
  wire logic host_mode_select_lo;
  wire logic host_mode_select_hi;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic serial_clock_en, dma_clock_en, timer_clock_en, unit_reset;
  logic irq_enable, arbiter_enable, bus_if_enable, pin_override;
  logic wait_out, wait_oe, bus_grant_chain_out, bus_request_out, int_oe;
  logic addr_hi_oe_allow, data_oe_allow, ctrl_oe_allow;
  logic [1:0] chip_mode;
  int errors = 0;
  int checks_done = 0;
  logic [DATA_W-1:0] rd;

  logic park = 1'b0;
  logic park_level = 1'b1;

  // Clock parks at park_level while park is set
  always #12.5 if (!park || clock != park_level) clock = ~clock;

  reset_source_model reset_source_model_i (.clock(clock), .reset_pin_n(reset_pin_n),
    .host_mode_select_lo(host_mode_select_lo), .host_mode_select_hi(host_mode_select_hi));

  chip_mode_controller chip_mode_controller_i (.clock(clock), .reset(reset),
    .reset_pin_n(reset_pin_n), .host_mode_select_lo(host_mode_select_lo),
    .host_mode_select_hi(host_mode_select_hi), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .serial_clock_en(serial_clock_en), .dma_clock_en(dma_clock_en),
    .timer_clock_en(timer_clock_en), .unit_reset(unit_reset), .irq_enable(irq_enable),
    .arbiter_enable(arbiter_enable), .bus_if_enable(bus_if_enable),
    .pin_override(pin_override), .wait_out(wait_out), .wait_oe(wait_oe),
    .bus_grant_chain_out(bus_grant_chain_out), .bus_request_out(bus_request_out),
    .int_oe(int_oe), .addr_hi_oe_allow(addr_hi_oe_allow), .data_oe_allow(data_oe_allow),
    .ctrl_oe_allow(ctrl_oe_allow), .chip_mode(chip_mode));

  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : reg_wr

  task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_rd

  task automatic wait_mode(input logic [1:0] m, input int limit);
    int n;
    n = 0;
    while (chip_mode !== m && n < limit) begin
      @(posedge clock);
      #1;
      n++;
    end
    `check_eq("chip_mode", m, chip_mode)
    @(posedge clock);
  endtask : wait_mode

  // Enables and pin overrides shared by reset and stop modes
  task automatic check_held(input logic [1:0] m, input logic req);
    `check_eq("held units", 3'h0, {serial_clock_en, dma_clock_en, timer_clock_en})
    `check_eq("held host", 3'h0, {irq_enable, arbiter_enable, bus_if_enable})
    `check_eq("held oe", 3'h0, {addr_hi_oe_allow, data_oe_allow, ctrl_oe_allow})
    `check_eq("wait pin", 3'h7, {pin_override, wait_out, wait_oe})
    `check_eq("grant chain", 1'b1, bus_grant_chain_out)
    `check_eq("int release", 1'b0, int_oe)
    `check_eq("bus request", req, bus_request_out)
    `check_eq("unit reset", m == MODE_CODE_RESET, unit_reset)
  endtask : check_held

  task automatic scen_power_on();
    repeat (15) @(posedge clock);
    #1;
    `check_eq("mode in reset", MODE_CODE_RESET, chip_mode)
    // Select sync reads mode 0 during reset, so the request line is low
    check_held(MODE_CODE_RESET, 1'b0);
    @(posedge clock);
    reset <= 1'b0;
    wait_mode(MODE_CODE_NORMAL, 40);
  endtask : scen_power_on

  task automatic scen_normal_regs();
    #1;
    `check_eq("run units", 3'h7, {serial_clock_en, dma_clock_en, timer_clock_en})
    `check_eq("run host", 3'h7, {irq_enable, arbiter_enable, bus_if_enable})
    `check_eq("no unit reset", 1'b0, unit_reset)
    `check_eq("run oe", 3'h7, {addr_hi_oe_allow, data_oe_allow, ctrl_oe_allow})
    `check_eq("no override", 2'h0, {pin_override, wait_oe})
    `check_eq("bus request idle", 1'b1, bus_request_out)
    reg_wr(LOW_POWER_CONTROL_ADDR, DATA_ZERO);
    `check_eq("stay normal", MODE_CODE_NORMAL, chip_mode)
    reg_rd(LOW_POWER_CONTROL_ADDR, rd);
    `check_eq("control read", DATA_ZERO, rd)
    reg_rd(MODE_STATUS_ADDR, rd);
    `check_eq("status read", {4'h0, 2'h1, MODE_CODE_NORMAL}, rd)
    @(posedge clock);
    #1;
    `check_eq("read data one cycle", DATA_ZERO, reg_rdata)
    reg_rd(8'h7f, rd);
    `check_eq("unmapped read", DATA_ZERO, rd)
  endtask : scen_normal_regs

  task automatic scen_short_pulse();
    reset_source_model_i.pulse_low(5);
    repeat (20) @(posedge clock);
    #1;
    `check_eq("short pulse", MODE_CODE_NORMAL, chip_mode)
    reset_source_model_i.pulse_low(4);
    reset_source_model_i.pulse_low(4);
    repeat (20) @(posedge clock);
    #1;
    `check_eq("split pulse", MODE_CODE_NORMAL, chip_mode)
  endtask : scen_short_pulse

  task automatic scen_stop(input logic req);
    @(posedge clock);
    reg_wr(LOW_POWER_CONTROL_ADDR, 8'h01);
    `check_eq("stop at write", MODE_CODE_STOP, chip_mode)
    check_held(MODE_CODE_STOP, req);
    reg_rd(MODE_STATUS_ADDR, rd);
    `check_eq("stopped read", DATA_ZERO, rd)
    reg_wr(LOW_POWER_CONTROL_ADDR, DATA_ZERO);
    repeat (10) @(posedge clock);
    #1;
    `check_eq("still stopped", MODE_CODE_STOP, chip_mode)
    park_level = req;
    park = 1'b1;
    #500;
    park = 1'b0;
    repeat (4) @(posedge clock);
    #1;
    `check_eq("stopped after clock halt", MODE_CODE_STOP, chip_mode)
  endtask : scen_stop

  task automatic scen_pin_reset(input logic req);
    fork
      reset_source_model_i.pulse_low(14);
    join_none
    wait_mode(MODE_CODE_RESET, 14);
    #1;
    check_held(MODE_CODE_RESET, req);
    wait fork;
    wait_mode(MODE_CODE_NORMAL, 14);
  endtask : scen_pin_reset

  // Mode 0 needs a fresh power-on, the select pins never move while running
  task automatic scen_cpu_mode0();
    @(posedge clock);
    reset <= 1'b1;
    reset_source_model_i.set_cpu_mode(CPU_MODE_0);
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    wait_mode(MODE_CODE_NORMAL, 40);
    reg_rd(MODE_STATUS_ADDR, rd);
    `check_eq("status mode0", {4'h0, CPU_MODE_0, MODE_CODE_NORMAL}, rd)
    scen_pin_reset(1'b0);
    scen_stop(1'b0);
  endtask : scen_cpu_mode0

  initial begin
    scen_power_on();
    scen_normal_regs();
    scen_short_pulse();
    scen_pin_reset(1'b1);
    scen_stop(1'b1);
    scen_pin_reset(1'b1);
    scen_normal_regs();
    scen_cpu_mode0();
    print_verdict();
  end

  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule : chip_mode_controller_tb_top
`default_nettype wire
